// ===== hdl/tqac_queue_ctrl.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - attention stays set until the builder can build, i.e. no backpressure
// - a new queue counts as started only when attention clears
// - unstructured high-speed mode ignores attention; queue 0 runs from enable
// - clearing an active bit takes effect at the next calendar entry
// - calendar entry spacing is frame count plus one frame periods
// - attention write merges the add table into calendar entry zero
// - attention reads back zero once the merge completes
module tqac_queue_ctrl #(
    parameter int FRAME_CYCLES_P = tqac_pkg::FRAME_CYCLES
) (
    input  wire logic                            sys_clk_i,
    input  wire logic                            sys_rst_i,
    input  wire logic [tqac_pkg::ADDR_W-1:0]     reg_addr_i,
    input  wire logic [31:0]                     reg_wdata_i,
    input  wire logic                            reg_wr_i,
    input  wire logic                            reg_rd_i,
    output logic      [31:0]                     reg_rdata_o,
    input  wire logic                            line_change_done_i,
    input  wire logic                            tx_cell_port_full_i,
    input  wire logic                            tx_byte_req_i,
    output logic                                 tx_byte_grant_o,
    output logic      [tqac_pkg::NQ-1:0]         queue_active_o,
    output logic      [tqac_pkg::NQ-1:0]         cal_entry0_o,
    output logic                                 sw_reset_o,
    output logic                                 cal_tick_o
);
    // every register of the block outside the calendar timer, updated together from next_st
    typedef struct packed {
        logic [31:0]                      rdata;
        logic                             sw_reset;
        logic                             sched_attn;
        logic                             line_attn;
        logic                             hs_mode;
        logic                             tx_en0;
        logic [tqac_pkg::NQ-1:0]          add_queue;
        logic [tqac_pkg::NQ-1:0]          active;
        logic [tqac_pkg::NQ-1:0]          cal_entry0;
        logic [tqac_pkg::NQ-1:0]          started;
        logic [tqac_pkg::FRAME_CNT_W-1:0] frame_cnt;
        tqac_pkg::tqac_sched_t            sched;
        logic                             full_meta;
        logic                             full_sync;
    } tqac_state_t;

    tqac_state_t           st;
    tqac_state_t           next_st;
    tqac_pkg::tqac_bus_req_t req;
    logic                  cal_tick;
    logic [tqac_pkg::NQ-1:0] run_mask;
    logic                  attn_set;  // attention written this cycle, kept over a clear

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    // decode used by both the write and the read path
    function automatic logic hit(input logic [tqac_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    tqac_calendar_timer #(
        .FRAME_CYCLES_P (FRAME_CYCLES_P)
    ) i_tqac_calendar_timer (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .hold_i      (st.sw_reset),
        .frame_cnt_i (st.frame_cnt),
        .cal_tick_o  (cal_tick)
    );

    // queue 0 in high-speed mode bypasses the scheduler entirely
    always_comb
    begin
        run_mask = st.started;
        if (st.hs_mode)
            run_mask[0] = !st.sw_reset && st.tx_en0;
    end

    // next-state logic for the whole block
    always_comb
    begin
        next_st           = st;
        attn_set          = 1'b0;
        // pin synchroniser; only full_sync is looked at
        next_st.full_meta = tx_cell_port_full_i;
        next_st.full_sync = st.full_meta;

        // register writes
        if (req.wr && hit(req.addr, tqac_pkg::REG_CMD))
        begin
            next_st.sw_reset = req.wdata[tqac_pkg::CMD_SW_RESET];
            next_st.hs_mode  = req.wdata[tqac_pkg::CMD_HS_MODE];
            next_st.tx_en0   = req.wdata[tqac_pkg::CMD_TX_EN0];
            // both attentions in one write: neither is taken
            if (req.wdata[tqac_pkg::CMD_SCHED_ATTN] && req.wdata[tqac_pkg::CMD_LINE_ATTN])
            begin
                next_st.sched_attn = st.sched_attn;
            end
            else
            begin
                if (req.wdata[tqac_pkg::CMD_SCHED_ATTN] && !st.hs_mode && !st.line_attn)
                begin
                    next_st.sched_attn = 1'b1;
                    attn_set           = 1'b1;
                end
                if (req.wdata[tqac_pkg::CMD_LINE_ATTN] && !st.sched_attn)
                    next_st.line_attn = 1'b1;
            end
        end
        if (req.wr && hit(req.addr, tqac_pkg::REG_ADD_QUEUE))
            next_st.add_queue = req.wdata;
        if (req.wr && hit(req.addr, tqac_pkg::REG_ACTIVE))
            next_st.active = req.wdata;
        if (req.wr && hit(req.addr, tqac_pkg::REG_FRAME_CNT))
            next_st.frame_cnt = req.wdata[tqac_pkg::FRAME_CNT_W-1:0];

        // line-change attention cleared by the line handler; a new set wins
        if (line_change_done_i && !(next_st.line_attn && !st.line_attn))
            next_st.line_attn = 1'b0;

        // scheduler merge sequence
        case (st.sched)
            tqac_pkg::TQAC_IDLE:
            begin
                if (st.sched_attn && !st.sw_reset && !st.hs_mode)
                    next_st.sched = tqac_pkg::TQAC_MERGE;
            end
            tqac_pkg::TQAC_MERGE:
            begin
                // add table is taken here, once software has finished with it
                next_st.cal_entry0 = st.cal_entry0 | st.add_queue;
                next_st.sched      = tqac_pkg::TQAC_WAIT;
            end
            tqac_pkg::TQAC_WAIT:
            begin
                // backpressure holds the bit; builder cannot take new cells
                if (!st.full_sync)
                begin
                    next_st.sched      = tqac_pkg::TQAC_IDLE;
                    // a request landing on the completion cycle wins over the clear,
                    // so it is merged again instead of being lost
                    if (!attn_set)
                        next_st.sched_attn = 1'b0;
                    next_st.started    = st.started | st.cal_entry0;
                end
            end
            default:
            begin
                next_st.sched = tqac_pkg::TQAC_IDLE;
            end
        endcase

        // cleared active bits only bite on a calendar entry
        if (cal_tick)
        begin
            next_st.started    = next_st.started & st.active;
            next_st.cal_entry0 = next_st.cal_entry0 & st.active;
        end

        // software reset stops scheduling, clears the scheduler attention, the started set and calendar entry zero, and keeps the other registers
        if (st.sw_reset)
        begin
            next_st.sched      = tqac_pkg::TQAC_IDLE;
            next_st.sched_attn = 1'b0;
            next_st.started    = '0;
            next_st.cal_entry0 = '0;
        end

        // read data one cycle after the strobe
        // unmapped offsets and idle cycles read as zero
        next_st.rdata = '0;
        if (req.rd)
        begin
            if (hit(req.addr, tqac_pkg::REG_CMD))
            begin
                next_st.rdata[tqac_pkg::CMD_SW_RESET]   = st.sw_reset;
                next_st.rdata[tqac_pkg::CMD_SCHED_ATTN] = st.sched_attn;
                next_st.rdata[tqac_pkg::CMD_LINE_ATTN]  = st.line_attn;
                next_st.rdata[tqac_pkg::CMD_HS_MODE]    = st.hs_mode;
                next_st.rdata[tqac_pkg::CMD_TX_EN0]     = st.tx_en0;
            end
            else if (hit(req.addr, tqac_pkg::REG_ADD_QUEUE))
                next_st.rdata = st.add_queue;
            else if (hit(req.addr, tqac_pkg::REG_ACTIVE))
                next_st.rdata = st.active;
            else if (hit(req.addr, tqac_pkg::REG_STARTED))
                next_st.rdata = run_mask;
            else if (hit(req.addr, tqac_pkg::REG_FRAME_CNT))
                next_st.rdata[tqac_pkg::FRAME_CNT_W-1:0] = st.frame_cnt;
        end
    end

    // single state register; reset values are constants from the package
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st           <= '0;
            st.sw_reset  <= tqac_pkg::SW_RESET_INIT;
            st.frame_cnt <= tqac_pkg::FRAME_CNT_INIT;
            st.sched     <= tqac_pkg::TQAC_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // two sync stages leave a small slip of bytes after full at the pin
    assign tx_byte_grant_o = tx_byte_req_i && !st.full_sync && !st.sw_reset;
    assign reg_rdata_o     = st.rdata;
    assign queue_active_o  = run_mask;
    assign cal_entry0_o    = st.cal_entry0;
    assign sw_reset_o      = st.sw_reset;
    assign cal_tick_o      = cal_tick;
endmodule : tqac_queue_ctrl

// ===== hdl/tqac_pkg.sv
package tqac_pkg;
    localparam int          NQ               = 32;
    localparam int          ADDR_W           = 8;
    localparam int          FRAME_CNT_W      = 4;
    localparam int          TMR_W            = 16;
    // register offsets, byte addresses
    localparam logic [7:0]  REG_CMD          = 8'h00;
    localparam logic [7:0]  REG_ADD_QUEUE    = 8'h04;
    localparam logic [7:0]  REG_ACTIVE       = 8'h08;
    localparam logic [7:0]  REG_STARTED      = 8'h0C;
    localparam logic [7:0]  REG_FRAME_CNT    = 8'h10;
    // command register fields
    localparam int          CMD_SW_RESET     = 5;
    localparam int          CMD_SCHED_ATTN   = 4;
    localparam int          CMD_LINE_ATTN    = 3;
    localparam int          CMD_HS_MODE      = 1;
    localparam int          CMD_TX_EN0       = 0;
    localparam logic        SW_RESET_INIT    = 1'b1;
    localparam logic [3:0]  FRAME_CNT_INIT   = 4'h0;
    // frame timing
    localparam int          FRAME_PERIOD_NS  = 125000;
    localparam int          CLK_PERIOD_NS    = 25;
    localparam int          FRAME_CYCLES     = FRAME_PERIOD_NS / CLK_PERIOD_NS;
    // at most this many bytes after full is seen at the pin
    localparam int          FULL_SLIP_BYTES  = 4;

    typedef enum logic [1:0] {
        TQAC_IDLE  = 2'b00,
        TQAC_MERGE = 2'b01,
        TQAC_WAIT  = 2'b10
    } tqac_sched_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } tqac_bus_req_t;
endpackage : tqac_pkg

// ===== hdl/tqac_calendar_timer.sv
`timescale 1ns/1ps
// paces calendar entries: one tick every (frame count + 1) frames
module tqac_calendar_timer #(
    parameter int FRAME_CYCLES_P = tqac_pkg::FRAME_CYCLES
) (
    input  wire logic                              sys_clk_i,
    input  wire logic                              sys_rst_i,
    input  wire logic                              hold_i,
    input  wire logic [tqac_pkg::FRAME_CNT_W-1:0]  frame_cnt_i,
    output logic                                   cal_tick_o
);
    typedef struct packed {
        logic [tqac_pkg::TMR_W-1:0]       cyc;
        logic [tqac_pkg::FRAME_CNT_W-1:0] frm;
        logic                             tick;
    } tqac_tmr_t;

    localparam logic [tqac_pkg::TMR_W-1:0] LAST_CYC =
        tqac_pkg::TMR_W'(FRAME_CYCLES_P - 1);

    tqac_tmr_t st;
    tqac_tmr_t next_st;

    // frame divider feeding the calendar entry counter
    always_comb
    begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (hold_i)
        begin
            next_st.cyc = '0;
            next_st.frm = '0;
        end
        else if (st.cyc == LAST_CYC)
        begin
            next_st.cyc = '0;
            if (st.frm == frame_cnt_i)
            begin
                next_st.frm  = '0;
                next_st.tick = 1'b1;
            end
            else
            begin
                next_st.frm = st.frm + 1'b1;
            end
        end
        else
        begin
            next_st.cyc = st.cyc + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign cal_tick_o = st.tick;
endmodule : tqac_calendar_timer

// ===== verif/tqac_queue_ctrl_properties.sv
`timescale 1ns/1ps
module tqac_checker #(
    parameter int FRAME_CYCLES_P = tqac_pkg::FRAME_CYCLES
) (
    input  wire logic                     sys_clk_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     reg_rd_i,
    input  wire logic [31:0]              reg_rdata_o,
    input  wire logic                     tx_cell_port_full_i,
    input  wire logic                     tx_byte_req_i,
    input  wire logic                     tx_byte_grant_o,
    input  wire logic [tqac_pkg::NQ-1:0]  queue_active_o,
    input  wire logic [tqac_pkg::NQ-1:0]  cal_entry0_o,
    input  wire logic                     sw_reset_o,
    input  wire logic                     cal_tick_o
);
    logic [31:0] gap;
    logic        seen;

    // span counter; the first span after soft reset is not judged, its start is loose
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            gap  <= 32'h0;
            seen <= 1'b0;
        end
        else
        begin
            gap  <= (cal_tick_o || sw_reset_o) ? 32'h0 : gap + 32'h1;
            seen <= sw_reset_o ? 1'b0 : (seen | cal_tick_o);
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_grant_gate: assert property (tx_byte_grant_o |-> tx_byte_req_i && !sw_reset_o)
        else $error("grant without request or during soft reset");
    chk_full_blocks: assert property (tx_cell_port_full_i [*3] |-> !tx_byte_grant_o)
        else $error("grant while full held three cycles");
    chk_entry_or: assert property (!cal_tick_o && !$past(cal_tick_o) && !sw_reset_o
        && !$past(sw_reset_o) |-> (cal_entry0_o & $past(cal_entry0_o)) == $past(cal_entry0_o))
        else $error("calendar entry lost bits outside a tick");
    chk_active_subset: assert property (
        (queue_active_o & ~cal_entry0_o & 32'hFFFF_FFFE) == 32'h0)
        else $error("running queue not in calendar entry");
    chk_start_source: assert property ((queue_active_o & ~$past(queue_active_o)
        & ~$past(cal_entry0_o) & 32'hFFFF_FFFE) == 32'h0)
        else $error("queue started before merge");
    chk_deact_tick: assert property (
        ($past(queue_active_o) & ~queue_active_o & 32'hFFFF_FFFE) != 32'h0
        |-> cal_tick_o || $past(cal_tick_o) || sw_reset_o || $past(sw_reset_o))
        else $error("queue stopped away from a calendar entry");
    chk_tick_span: assert property (cal_tick_o && seen |->
        (gap + 32'h1) % FRAME_CYCLES_P == 0 && gap < 16 * FRAME_CYCLES_P)
        else $error("calendar tick spacing wrong");
    chk_tick_held: assert property (sw_reset_o && $past(sw_reset_o) |-> !cal_tick_o)
        else $error("calendar tick during soft reset");
    chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read answer cycle");
endmodule : tqac_checker

bind tqac_queue_ctrl tqac_checker #(.FRAME_CYCLES_P(FRAME_CYCLES_P)) i_tqac_checker (
    .sys_clk_i, .sys_rst_i, .reg_rd_i, .reg_rdata_o, .tx_cell_port_full_i, .tx_byte_req_i,
    .tx_byte_grant_o, .queue_active_o, .cal_entry0_o, .sw_reset_o, .cal_tick_o
);

// ===== verif/tqac_queue_ctrl_bench.sv
`timescale 1ns/1ps
module tqac_queue_ctrl_bench;
    // short frame keeps calendar spans at 20 cycles
    localparam int FC = 10;

    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        done      = 1'b0;
    logic        full      = 1'b0;
    logic        req       = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic [31:0] wdata     = 32'h0;
    logic [31:0] rdata;
    logic [31:0] act;
    logic [31:0] ent;
    logic [31:0] d;
    logic        grant;
    logic        swr;
    logic        tick;
    int          errors    = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    int          n;
    int          t0;

    always #12.5 clk = ~clk;

    // device under test
    tqac_queue_ctrl #(
        .FRAME_CYCLES_P      (FC)
    ) i_tqac_queue_ctrl (
        .sys_clk_i           (clk),
        .sys_rst_i           (rst),
        .reg_addr_i          (addr),
        .reg_wdata_i         (wdata),
        .reg_wr_i            (wr),
        .reg_rd_i            (rd),
        .reg_rdata_o         (rdata),
        .line_change_done_i  (done),
        .tx_cell_port_full_i (full),
        .tx_byte_req_i       (req),
        .tx_byte_grant_o     (grant),
        .queue_active_o      (act),
        .cal_entry0_o        (ent),
        .sw_reset_o          (swr),
        .cal_tick_o          (tick)
    );

    task test_done;
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // hang guard, well above the hundred-odd cycles the run needs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            errors++;
            test_done();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one-cycle write strobe
    task wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wreg

    // one-cycle read strobe; data taken mid-cycle while it stands
    task rreg(input logic [7:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rreg

    task wait_tick;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (tick !== 1'b1 && n < 200);
    endtask : wait_tick

    // polls until the merge reports done, bounded
    task poll_attn;
        n = 0;
        do
        begin
            rreg(tqac_pkg::REG_CMD);
            n++;
        end
        while (d[tqac_pkg::CMD_SCHED_ATTN] !== 1'b0 && n < 20);
    endtask : poll_attn

    // merge completion held off by backpressure, then completes
    task t_attn;
        wreg(tqac_pkg::REG_FRAME_CNT, 32'h1);
        wreg(tqac_pkg::REG_CMD, 32'h0);
        wreg(tqac_pkg::REG_ACTIVE, 32'hFFFF_FFFF);
        wreg(tqac_pkg::REG_ADD_QUEUE, 32'h6);
        @(posedge clk) full <= 1'b1;
        wreg(tqac_pkg::REG_CMD, 32'h10);
        repeat (8) @(posedge clk);
        rreg(tqac_pkg::REG_CMD);
        chk(d, 32'h10);
        chk(ent, 32'h6);
        chk(act, 32'h0);
        @(posedge clk) full <= 1'b0;
        poll_attn();
        chk(d, 32'h0);
        chk(act, 32'h6);
        rreg(tqac_pkg::REG_STARTED);
        chk(d, 32'h6);
        wreg(tqac_pkg::REG_ADD_QUEUE, 32'h0);
    endtask : t_attn

    // clearing an active bit waits for the next calendar entry, then reuse
    task t_deact;
        wait_tick();
        t0 = cyc;
        wreg(tqac_pkg::REG_ACTIVE, 32'hFFFF_FFFD);
        @(negedge clk);
        chk(act, 32'h6);
        wait_tick();
        chk(act, 32'h6);
        chk(cyc - t0, (32'h1 + 32'h1) * FC);
        repeat (2) @(negedge clk);
        chk(act, 32'h4);
        chk(ent, 32'h4);
        wreg(tqac_pkg::REG_ACTIVE, 32'hFFFF_FFFF);
        wreg(tqac_pkg::REG_ADD_QUEUE, 32'h2);
        wreg(tqac_pkg::REG_CMD, 32'h10);
        poll_attn();
        chk(d, 32'h0);
        chk(ent, 32'h6);
        chk(act, 32'h6);
        wreg(tqac_pkg::REG_ADD_QUEUE, 32'h0);
    endtask : t_deact

    // byte grant stops within the slip after full, resumes when it drops
    task t_grant;
        @(posedge clk) req <= 1'b1;
        @(negedge clk) chk(grant, 1'b1);
        @(posedge clk) full <= 1'b1;
        n = 0;
        repeat (6)
        begin
            @(negedge clk);
            if (grant === 1'b1)
                n++;
        end
        chk(n > tqac_pkg::FULL_SLIP_BYTES, 1'b0);
        chk(grant, 1'b0);
        @(posedge clk) full <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk) chk(grant, 1'b1);
        @(posedge clk) req <= 1'b0;
    endtask : t_grant

    // both attentions at once are dropped; scheduler request ignored while line busy
    task t_line;
        wreg(tqac_pkg::REG_CMD, 32'h18);
        rreg(tqac_pkg::REG_CMD);
        chk(d, 32'h0);
        wreg(tqac_pkg::REG_CMD, 32'h08);
        rreg(tqac_pkg::REG_CMD);
        chk(d, 32'h8);
        wreg(tqac_pkg::REG_CMD, 32'h10);
        rreg(tqac_pkg::REG_CMD);
        chk(d, 32'h8);
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        rreg(tqac_pkg::REG_CMD);
        chk(d, 32'h0);
        rreg(8'h14);
        chk(d, 32'h0);
    endtask : t_line

    // high-speed mode: queue 0 follows reset and enable, attention unused
    task t_hs;
        wreg(tqac_pkg::REG_CMD, 32'h23);
        repeat (2) @(negedge clk);
        chk(act, 32'h0);
        wreg(tqac_pkg::REG_CMD, 32'h13);
        repeat (2) @(negedge clk);
        chk(act, 32'h1);
        rreg(tqac_pkg::REG_CMD);
        chk(d, 32'h3);
        wreg(tqac_pkg::REG_CMD, 32'h2);
        repeat (2) @(negedge clk);
        chk(act, 32'h0);
    endtask : t_hs

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk) chk(swr, 1'b1);
        chk(act, 32'h0);
        rreg(tqac_pkg::REG_CMD);
        chk(d, 32'h20);
        t_attn();
        t_deact();
        t_grant();
        t_line();
        t_hs();
        test_done();
    end
endmodule : tqac_queue_ctrl_bench
